// ### tsc_consts.svh
// Offsets, field positions, reset values and write masks of the slave trigger control block
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH
`define TSC_OFF_SLAVE_MODE_CONTROL 8'h08
`define TSC_OFF_IRQ_DMA_ENABLE 8'h0c
`define TSC_RST_SLAVE_MODE_CONTROL 16'h0000
`define TSC_RST_IRQ_DMA_ENABLE 16'h0000
`define TSC_MODE_CTL_WMASK 16'hfff7
`define TSC_REQ_EN_WMASK 16'h7fff
`define TSC_BIT_EXT_POL 15
`define TSC_BIT_EXT_CLK2 14
`define TSC_POS_EXT_PRESC 12
`define TSC_POS_EXT_FILT 8
`define TSC_BIT_SYNC_DLY 7
`define TSC_POS_TRIG_SEL 4
`define TSC_POS_SLAVE_MODE 0
`define TSC_POS_DMA_EN 8
`define TSC_POS_IRQ_EN 0
`define TSC_SEL_EXT_FILT 3'h7
`define TSC_SEL_INPUT1_EDGE 3'h4
`endif

// ### tsc_pkg.sv
// Types shared by the slave trigger control block
`default_nettype none
package tsc_pkg;
  typedef enum logic [2:0] {
    TSC_SM_OFF = 3'h0,
    TSC_SM_ENC1 = 3'h1,
    TSC_SM_ENC2 = 3'h2,
    TSC_SM_ENC3 = 3'h3,
    TSC_SM_RESET = 3'h4,
    TSC_SM_GATED = 3'h5,
    TSC_SM_TRIGGER = 3'h6,
    TSC_SM_EXTCLK1 = 3'h7
  } tsc_mode_type;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tsc_bus_req_type;
  // Commands to the counter core
  typedef struct packed {
    logic tick;
    logic dir_down;
    logic reinit;
    logic start;
    logic trigger_event;
  } tsc_cnt_cmd_type;
  // Filter setting: log2 of sample divider (0 = every sampling clock tick), N, and dts-based flag
  typedef struct packed {
    logic use_dts;
    logic [2:0] div_log2;
    logic [3:0] n;
  } tsc_filt_type;
endpackage : tsc_pkg
`default_nettype wire

// ### tsc_slave_trigger.sv
// Slave mode and trigger conditioning logic of a timer, with request enable register
//==============================================================
// Contract
// RULE1: Polarity bit 1 inverts the external trigger pin, 0 passes it.
// RULE2: Clock mode 2 advances the counter on each conditioned external trigger edge.
// RULE3: With both clock modes set, counting clock comes from filtered external trigger.
// RULE4: Software avoids selecting external trigger as source with clock mode 2 plus slave mode.
// RULE5: Two-bit prescaler divides external trigger by 1, 2, 4 or 8.
// RULE6: Prescaled trigger toggles no faster than quarter of the kernel clock.
// RULE7: Filter passes a new level after N consecutive agreeing samples.
// RULE8: Filter code 0 unfiltered at sampling clock; codes 1-3 at clock, N 2/4/8.
// RULE9: Codes 4-15 sample at sampling clock divided 2..32 with their N.
// RULE10: Sync bit delays internal effect of each trigger input event.
// RULE11: Trigger select picks internal triggers, input-1 edge, inputs 1/2 or external.
// RULE12: Software changes trigger select only while the trigger is unused.
// RULE13: Mode 000 ticks the prescaler from the clock while counter is enabled.
// RULE14: Encoder modes count on input edges, direction from the other input.
// RULE15: Reset mode: trigger rising edge reinitialises counter and requests update.
// RULE16: Gated mode: counter runs only while trigger high, halts without reset.
// RULE17: Trigger mode: trigger rising edge starts counter without reset.
// RULE18: Clock mode 1: each trigger rising edge advances the counter.
// RULE19: Software avoids gated mode with the input-1 edge source.
// RULE20: Enable register gates DMA requests, bits 14 down to 8.
// RULE21: Enable register gates interrupts, bits 7 down to 0.
// RULE22: A request is high while its event flag and enable bit are both set.
// RULE23: Sampling clock is 1, 2 or 4 clocks for divider codes 0, 1, 2.
// RULE24: Clock, gated and encoder modes need counter enable; trigger mode sets it.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "tsc_consts.svh"
`default_nettype none

module tsc_slave_trigger (
  input wire logic clk,
  input wire logic rst,
  input wire tsc_pkg::tsc_bus_req_type bus_req,
  output logic [15:0] bus_rdata,
  input wire logic counter_enable_bit,
  input wire logic [1:0] sampling_clock_divider,
  input wire logic ext_trigger_pin,
  input wire logic [3:0] internal_trigger,
  input wire logic input1_edge_pulse,
  input wire logic filtered_input_1,
  input wire logic filtered_input_2,
  input wire logic [7:0] event_flags,
  output var tsc_pkg::tsc_cnt_cmd_type cnt_cmd,
  output logic ext_trigger_filtered,
  output logic [7:0] irq_req,
  output logic [6:0] dma_req
);
  import tsc_pkg::*;

  //==============================================================
  // Decode helpers
  function automatic tsc_filt_type filt_cfg(input logic [3:0] code);
    tsc_filt_type f;
    f = '{use_dts: 1'b1, div_log2: 3'h0, n: 4'h1};
    case (code)
      4'h0: f = '{use_dts: 1'b1, div_log2: 3'h0, n: 4'h1};
      4'h1: f = '{use_dts: 1'b0, div_log2: 3'h0, n: 4'h2};
      4'h2: f = '{use_dts: 1'b0, div_log2: 3'h0, n: 4'h4};
      4'h3: f = '{use_dts: 1'b0, div_log2: 3'h0, n: 4'h8};
      4'h4: f = '{use_dts: 1'b1, div_log2: 3'h1, n: 4'h6};
      4'h5: f = '{use_dts: 1'b1, div_log2: 3'h1, n: 4'h8};
      4'h6: f = '{use_dts: 1'b1, div_log2: 3'h2, n: 4'h6};
      4'h7: f = '{use_dts: 1'b1, div_log2: 3'h2, n: 4'h8};
      4'h8: f = '{use_dts: 1'b1, div_log2: 3'h3, n: 4'h6};
      4'h9: f = '{use_dts: 1'b1, div_log2: 3'h3, n: 4'h8};
      4'ha: f = '{use_dts: 1'b1, div_log2: 3'h4, n: 4'h5};
      4'hb: f = '{use_dts: 1'b1, div_log2: 3'h4, n: 4'h6};
      4'hc: f = '{use_dts: 1'b1, div_log2: 3'h4, n: 4'h8};
      4'hd: f = '{use_dts: 1'b1, div_log2: 3'h5, n: 4'h5};
      4'he: f = '{use_dts: 1'b1, div_log2: 3'h5, n: 4'h6};
      4'hf: f = '{use_dts: 1'b1, div_log2: 3'h5, n: 4'h8};
      default: f = '{use_dts: 1'b1, div_log2: 3'h0, n: 4'h1};
    endcase
    return f;
  endfunction

  function automatic logic [4:0] low_mask(input logic [2:0] log2);
    logic [5:0] one_hot;
    one_hot = 6'h01 << log2;
    return 5'(one_hot - 6'h01);
  endfunction

  //==============================================================
  // Registers
  logic [15:0] mode_ctl_r;
  logic [15:0] req_en_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ctl_r <= `TSC_RST_SLAVE_MODE_CONTROL;
    end else if (bus_req.wr && bus_req.addr == `TSC_OFF_SLAVE_MODE_CONTROL) begin
      mode_ctl_r <= bus_req.wdata & `TSC_MODE_CTL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_en_r <= `TSC_RST_IRQ_DMA_ENABLE;
    end else if (bus_req.wr && bus_req.addr == `TSC_OFF_IRQ_DMA_ENABLE) begin
      req_en_r <= bus_req.wdata & `TSC_REQ_EN_WMASK;
    end
  end

  // Unmapped addresses read as zero; reserved bits are never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `TSC_OFF_SLAVE_MODE_CONTROL: bus_rdata <= mode_ctl_r;
        `TSC_OFF_IRQ_DMA_ENABLE: bus_rdata <= req_en_r;
        default: bus_rdata <= 16'h0000;
      endcase
    end
  end

  logic ext_trigger_polarity;
  logic ext_clock_mode2_enable;
  logic [1:0] ext_trigger_prescale;
  logic [3:0] ext_trigger_filter;
  logic master_slave_sync_delay;
  logic [2:0] trigger_source_select;
  tsc_mode_type slave_mode_select;

  assign ext_trigger_polarity = mode_ctl_r[`TSC_BIT_EXT_POL];
  assign ext_clock_mode2_enable = mode_ctl_r[`TSC_BIT_EXT_CLK2];
  assign ext_trigger_prescale = mode_ctl_r[`TSC_POS_EXT_PRESC +: 2];
  assign ext_trigger_filter = mode_ctl_r[`TSC_POS_EXT_FILT +: 4];
  assign master_slave_sync_delay = mode_ctl_r[`TSC_BIT_SYNC_DLY];
  assign trigger_source_select = mode_ctl_r[`TSC_POS_TRIG_SEL +: 3];
  assign slave_mode_select = tsc_mode_type'(mode_ctl_r[`TSC_POS_SLAVE_MODE +: 3]);

  //==============================================================
  // Sampling clock enable
  logic [1:0] dts_cnt_r;
  logic [1:0] dts_top;
  logic dts_en;

  // Reserved divider code behaves as divide by four
  assign dts_top = (sampling_clock_divider == 2'h0) ? 2'h0 :
                   (sampling_clock_divider == 2'h1) ? 2'h1 : 2'h3; // [RULE23]
  assign dts_en = (dts_cnt_r == dts_top);

  always_ff @(posedge clk) begin
    if (rst || dts_en) begin
      dts_cnt_r <= 2'h0;
    end else begin
      dts_cnt_r <= dts_cnt_r + 2'h1;
    end
  end

  //==============================================================
  // External trigger polarity and prescaler
  logic ext_trigger_pol_r;
  logic ext_trigger_pol_d_r;
  logic [2:0] ext_pres_cnt_r;
  logic ext_trigger_prescaled;

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_trigger_pol_r <= 1'b0;
      ext_trigger_pol_d_r <= 1'b0;
    end else begin
      ext_trigger_pol_r <= ext_trigger_pin ^ ext_trigger_polarity; // [RULE1]
      ext_trigger_pol_d_r <= ext_trigger_pol_r;
    end
  end

  // Counting rising edges; bit k toggles at 1/2^k of the edge rate
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_pres_cnt_r <= 3'h0;
    end else if (ext_trigger_pol_r && !ext_trigger_pol_d_r) begin
      ext_pres_cnt_r <= ext_pres_cnt_r + 3'h1;
    end
  end

  always_comb begin
    case (ext_trigger_prescale) // [RULE5]
      2'h0: ext_trigger_prescaled = ext_trigger_pol_r;
      2'h1: ext_trigger_prescaled = ext_pres_cnt_r[0];
      2'h2: ext_trigger_prescaled = ext_pres_cnt_r[1];
      default: ext_trigger_prescaled = ext_pres_cnt_r[2];
    endcase
  end

  //==============================================================
  // Digital filter
  tsc_filt_type fcfg;
  logic [4:0] samp_div_r;
  logic samp_en;
  logic [3:0] filt_cnt_r;

  assign fcfg = filt_cfg(ext_trigger_filter);
  assign samp_en = fcfg.use_dts ?
                   (dts_en && ((samp_div_r & low_mask(fcfg.div_log2)) == 5'h00)) :
                   1'b1; // [RULE8] [RULE9]

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_div_r <= 5'h00;
    end else if (dts_en) begin
      samp_div_r <= samp_div_r + 5'h01;
    end
  end

  // Any disagreeing sample restarts the run count
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_cnt_r <= 4'h0;
      ext_trigger_filtered <= 1'b0;
    end else if (samp_en) begin
      if (ext_trigger_prescaled == ext_trigger_filtered) begin
        filt_cnt_r <= 4'h0;
      end else if (filt_cnt_r + 4'h1 >= fcfg.n) begin
        filt_cnt_r <= 4'h0;
        ext_trigger_filtered <= ext_trigger_prescaled; // [RULE7]
      end else begin
        filt_cnt_r <= filt_cnt_r + 4'h1;
      end
    end
  end

  //==============================================================
  // Trigger selection and edge detection
  logic trigger_input;
  logic trig_r;
  logic trig_rise;
  logic trig_dly_r;
  logic rise_dly_r;
  logic trig_eff;
  logic rise_eff;
  logic extf_d_r;
  logic extf_rise;

  always_comb begin
    case (trigger_source_select) // [RULE11]
      3'h0: trigger_input = internal_trigger[0];
      3'h1: trigger_input = internal_trigger[1];
      3'h2: trigger_input = internal_trigger[2];
      3'h3: trigger_input = internal_trigger[3];
      `TSC_SEL_INPUT1_EDGE: trigger_input = input1_edge_pulse;
      3'h5: trigger_input = filtered_input_1;
      3'h6: trigger_input = filtered_input_2;
      default: trigger_input = ext_trigger_filtered;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_r <= 1'b0;
      trig_dly_r <= 1'b0;
      rise_dly_r <= 1'b0;
      extf_d_r <= 1'b0;
    end else begin
      trig_r <= trigger_input;
      trig_dly_r <= trig_r;
      rise_dly_r <= trig_rise;
      extf_d_r <= ext_trigger_filtered;
    end
  end

  // The edge pulse source is already one pulse per transition
  assign trig_rise = (trigger_source_select == `TSC_SEL_INPUT1_EDGE) ?
                     trig_r : (trigger_input && !trig_r);
  // One extra cycle lets the slaves see our trigger output in step
  assign trig_eff = master_slave_sync_delay ? trig_dly_r : trig_r; // [RULE10]
  assign rise_eff = master_slave_sync_delay ? rise_dly_r : trig_rise; // [RULE10]
  assign extf_rise = ext_trigger_filtered && !extf_d_r;

  //==============================================================
  // Encoder edges
  logic fi1_d_r;
  logic fi2_d_r;
  logic fi1_edge;
  logic fi2_edge;

  always_ff @(posedge clk) begin
    if (rst) begin
      fi1_d_r <= 1'b0;
      fi2_d_r <= 1'b0;
    end else begin
      fi1_d_r <= filtered_input_1;
      fi2_d_r <= filtered_input_2;
    end
  end

  assign fi1_edge = filtered_input_1 ^ fi1_d_r;
  assign fi2_edge = filtered_input_2 ^ fi2_d_r;

  //==============================================================
  // Slave mode controller
  logic tick_nxt;
  logic dir_nxt;
  logic reinit_nxt;
  logic start_nxt;
  logic tevent_nxt;
  logic base_clk;
  logic gate_r;
  logic dir_r;

  // Clock mode 2 replaces the internal clock source in every mode but encoders
  assign base_clk = ext_clock_mode2_enable ? extf_rise : 1'b1; // [RULE2] [RULE4]

  always_comb begin
    tick_nxt = 1'b0;
    dir_nxt = dir_r;
    reinit_nxt = 1'b0;
    start_nxt = 1'b0;
    tevent_nxt = 1'b0;
    case (slave_mode_select)
      TSC_SM_OFF: begin
        tick_nxt = counter_enable_bit && base_clk; // [RULE13] [RULE24]
      end
      TSC_SM_ENC1: begin
        tick_nxt = counter_enable_bit && fi2_edge; // [RULE14]
        dir_nxt = fi2_edge ? (filtered_input_2 == filtered_input_1) : dir_r;
      end
      TSC_SM_ENC2: begin
        tick_nxt = counter_enable_bit && fi1_edge; // [RULE14]
        dir_nxt = fi1_edge ? (filtered_input_1 != filtered_input_2) : dir_r;
      end
      TSC_SM_ENC3: begin
        tick_nxt = counter_enable_bit && (fi1_edge || fi2_edge); // [RULE14]
        if (fi1_edge) begin
          dir_nxt = (filtered_input_1 != filtered_input_2);
        end else if (fi2_edge) begin
          dir_nxt = (filtered_input_2 == filtered_input_1);
        end
      end
      TSC_SM_RESET: begin
        tick_nxt = counter_enable_bit && base_clk;
        reinit_nxt = rise_eff; // [RULE15]
        tevent_nxt = rise_eff;
      end
      TSC_SM_GATED: begin
        // Level source only; the edge pulse source gives a meaningless gate
        tick_nxt = counter_enable_bit && trig_eff && base_clk; // [RULE16] [RULE19]
        tevent_nxt = (trig_eff != gate_r);
      end
      TSC_SM_TRIGGER: begin
        start_nxt = rise_eff; // [RULE17] [RULE24]
        tick_nxt = counter_enable_bit && base_clk;
        tevent_nxt = rise_eff;
      end
      TSC_SM_EXTCLK1: begin
        // Both clock modes together: the filtered external trigger is the clock
        tick_nxt = counter_enable_bit &&
                   (ext_clock_mode2_enable ? extf_rise : rise_eff); // [RULE18] [RULE3]
        tevent_nxt = rise_eff;
      end
      default: begin
        tick_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_r <= 1'b0;
      dir_r <= 1'b0;
    end else begin
      gate_r <= trig_eff;
      dir_r <= dir_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_cmd <= '0;
    end else begin
      cnt_cmd.tick <= tick_nxt;
      cnt_cmd.dir_down <= dir_nxt;
      cnt_cmd.reinit <= reinit_nxt;
      cnt_cmd.start <= start_nxt;
      cnt_cmd.trigger_event <= tevent_nxt;
    end
  end

  //==============================================================
  // Interrupt and DMA request gating
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req <= 8'h00;
      dma_req <= 7'h00;
    end else begin
      irq_req <= event_flags & req_en_r[`TSC_POS_IRQ_EN +: 8]; // [RULE21] [RULE22]
      dma_req <= event_flags[6:0] & req_en_r[`TSC_POS_DMA_EN +: 7]; // [RULE20] [RULE22]
    end
  end

endmodule // tsc_slave_trigger

`default_nettype wire

// ### tsc_slave_trigger_chk.sv
// Port checker of the slave trigger control block and its bind
`timescale 1ns/10ps
`default_nettype none
module tsc_slave_trigger_chk (
  input wire logic clk,
  input wire logic rst,
  input wire tsc_pkg::tsc_bus_req_type bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic counter_enable_bit,
  input wire logic [3:0] internal_trigger,
  input wire logic [7:0] event_flags,
  input wire tsc_pkg::tsc_cnt_cmd_type cnt_cmd,
  input wire logic [7:0] irq_req,
  input wire logic [6:0] dma_req
);
  import tsc_pkg::*;
  logic [15:0] mode_sh, en_sh, en_q;
  logic [7:0] flags_q;
  logic plain;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  //==========================================
  // Register shadows rebuilt from bus writes, plus one-cycle copies of the enable shadow and the event flags
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_sh <= 16'h0000;
      en_sh <= 16'h0000;
      en_q <= 16'h0000;
      flags_q <= 8'h00;
    end else begin
      if (bus_req.wr && bus_req.addr == 8'h08) begin
        mode_sh <= bus_req.wdata & 16'hfff7;
      end
      if (bus_req.wr && bus_req.addr == 8'h0c) begin
        en_sh <= bus_req.wdata & 16'h7fff;
      end
      en_q <= en_sh;
      flags_q <= event_flags;
    end
  end
  // Source 0, no prescale, filter or clock mode 2; the sync bit is judged apart
  assign plain = mode_sh[14:8] == 7'h00 && mode_sh[6:4] == 3'h0;
  //==========================================
  // Assertions
  a_irq_gate: assert property (irq_req == (flags_q & en_q[7:0]))
    else $error("interrupt request is not flags and enables");
  a_dma_gate: assert property (dma_req == (flags_q[6:0] & en_q[14:8]))
    else $error("dma request is not flags and enables");
  a_read_mode: assert property (bus_req.rd && bus_req.addr == 8'h08
    |=> bus_rdata == $past(mode_sh)) else $error("mode register read back wrong");
  a_read_unmapped: assert property (bus_req.rd && bus_req.addr != 8'h08
    && bus_req.addr != 8'h0c |=> bus_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!bus_req.rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_tick_enable: assert property ((!counter_enable_bit)[*4] |-> !cnt_cmd.tick)
    else $error("tick while counter disabled");
  a_clock1_tick: assert property ($rose(internal_trigger[0]) && plain && !mode_sh[7]
    && mode_sh[2:0] == 3'h7 && counter_enable_bit |-> ##1 cnt_cmd.tick && cnt_cmd.trigger_event)
    else $error("trigger edge did not clock the counter");
  a_sync_delay: assert property ($rose(internal_trigger[0]) && plain && mode_sh[7]
    && mode_sh[2:0] == 3'h7 && counter_enable_bit |-> ##1 !cnt_cmd.tick ##1 cnt_cmd.tick)
    else $error("sync delay not one cycle");
  a_reset_reinit: assert property ($rose(internal_trigger[0]) && plain && !mode_sh[7]
    && mode_sh[2:0] == 3'h4 |-> ##1 cnt_cmd.reinit) else $error("no reinit on trigger edge");
  a_trig_start: assert property ($rose(internal_trigger[0]) && plain && !mode_sh[7]
    && mode_sh[2:0] == 3'h6 |-> ##1 cnt_cmd.start) else $error("no start on trigger edge");
  c_reinit: cover property (cnt_cmd.reinit);
  c_start: cover property (cnt_cmd.start);
  c_dma: cover property (|dma_req);
endmodule // tsc_slave_trigger_chk
bind tsc_slave_trigger tsc_slave_trigger_chk u_chk (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .counter_enable_bit(counter_enable_bit),
  .internal_trigger(internal_trigger), .event_flags(event_flags), .cnt_cmd(cnt_cmd),
  .irq_req(irq_req), .dma_req(dma_req));
`default_nettype wire

// ### tsc_far_model.sv
// Far-side model: trigger pin, timer input stage and other timers' triggers
`timescale 1ns/10ps
`default_nettype none
module tsc_far_model (
  input wire logic clk,
  input wire logic toggle_en,
  input wire logic ext_lvl,
  input wire logic [3:0] it_lvl,
  input wire logic in1_lvl,
  input wire logic in2_lvl,
  output logic ext_trigger_pin,
  output logic [3:0] internal_trigger,
  output logic input1_edge_pulse,
  output logic filtered_input_1,
  output logic filtered_input_2
);
  logic ph_r = 1'b0;
  //==========================================
  // Pin toggles every second clock, so it never exceeds a quarter of the kernel rate
  always_ff @(posedge clk) begin
    ph_r <= ~ph_r;
    ext_trigger_pin <= toggle_en ? (ext_trigger_pin ^ ph_r) : ext_lvl;
    internal_trigger <= it_lvl;
    filtered_input_1 <= in1_lvl;
    filtered_input_2 <= in2_lvl;
    input1_edge_pulse <= in1_lvl ^ filtered_input_1;
  end
endmodule // tsc_far_model
`default_nettype wire

// ### tsc_slave_trigger_tb.sv
// Self-checking bench of the slave trigger control block
`timescale 1ns/10ps
`default_nettype none
module tsc_slave_trigger_tb;
  import tsc_pkg::*;
  logic clk, rst, en, tog, ext, in1, in2, ext_filt_o, pin, iep, fi1, fi2, ld, d0;
  logic [1:0] div;
  logic [3:0] itl, itr;
  logic [7:0] ev, irq;
  logic [6:0] dma;
  logic [15:0] rdata, m;
  tsc_bus_req_type req;
  tsc_cnt_cmd_type cmd;
  int n_fail, num_checks, nt, nr, ns;
  int gl[3] = '{6, 30, 240};
  int st[3] = '{20, 80, 360};
  logic [3:0] fc[3] = '{4'h3, 4'h4, 4'hd};
  logic [1:0] dv[3] = '{2'h0, 2'h2, 2'h1};
  tsc_slave_trigger u_dut (.clk(clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
    .counter_enable_bit(en), .sampling_clock_divider(div), .ext_trigger_pin(pin),
    .internal_trigger(itr), .input1_edge_pulse(iep), .filtered_input_1(fi1),
    .filtered_input_2(fi2), .event_flags(ev), .cnt_cmd(cmd),
    .ext_trigger_filtered(ext_filt_o), .irq_req(irq), .dma_req(dma));
  tsc_far_model u_far (.clk(clk), .toggle_en(tog), .ext_lvl(ext), .it_lvl(itl),
    .in1_lvl(in1), .in2_lvl(in2), .ext_trigger_pin(pin), .internal_trigger(itr),
    .input1_edge_pulse(iep), .filtered_input_1(fi1), .filtered_input_2(fi2));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counted at the falling edge, away from the edge where the bench drives
  always @(negedge clk) begin
    nt += int'(cmd.tick);
    nr += int'(cmd.reinit);
    ns += int'(cmd.start);
    if (cmd.tick) ld = cmd.dir_down;
  end
  //==========================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk(16'(v >= lo && v <= hi), 16'h0001);
  endtask
  task automatic run(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic cfg(input logic [15:0] v);
    wr(8'h08, v & 16'hfff8);
    wr(8'h08, v);
    run(6);
    nt = 0;
    nr = 0;
    ns = 0;
  endtask
  task automatic src(input logic [2:0] sel, input logic v);
    case (sel)
      3'h4, 3'h5: in1 <= v;
      3'h6: in2 <= v;
      3'h7: ext <= v;
      default: itl[sel[1:0]] <= v;
    endcase
  endtask
  task automatic pulse(input logic [2:0] ts);
    src(ts, 1'b1);
    run(10);
    src(ts, 1'b0);
    run(12);
  endtask
  task automatic tend(input string s);
    $display("%0t test %s done", $time, s);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang is cut off far beyond the few thousand cycles the tests need
  initial begin
    #100000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test;
  end
  //==========================================
  // Tests
  initial begin
    {rst, en, tog, ext, in1, in2, ld, div, itl, ev} = 21'h100000;
    req = '0;
    {n_fail, num_checks, nt, nr, ns} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h08, 16'h0000);
    rd(8'h0c, 16'h0000);
    wr(8'h08, 16'hffff);
    rd(8'h08, 16'hfff7);
    wr(8'h0c, 16'hffff);
    rd(8'h0c, 16'h7fff);
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h0000);
    tend("registers");
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 16'h7fff : (i == 1) ? 16'h2a55 : 16'h55aa;
      wr(8'h0c, m);
      ev <= 8'hff >> i;
      run(3);
      chk({1'b0, dma, irq}, {1'b0, m[14:8] & ev[6:0], m[7:0] & ev});
    end
    ev <= 8'h00;
    tend("requests");
    cfg(16'h0000);
    ext <= 1'b1;
    run(8);
    chk(16'(ext_filt_o), 16'h0001);
    cfg(16'h8000);
    chk(16'(ext_filt_o), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      cfg({4'h0, fc[i], 8'h00});
      div <= dv[i];
      ext <= 1'b1;
      run(st[i]);
      chk(16'(ext_filt_o), 16'h0001);
      ext <= 1'b0;
      run(gl[i]);
      chk(16'(ext_filt_o), 16'h0001);
      ext <= 1'b1;
      run(st[i]);
      chk(16'(ext_filt_o), 16'h0001);
      ext <= 1'b0;
      run(st[i]);
      chk(16'(ext_filt_o), 16'h0000);
    end
    div <= 2'h0;
    tend("filter");
    en <= 1'b1;
    tog <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      cfg((i < 4) ? (16'h4000 | (16'(i) << 12)) : 16'h4007);
      run(400);
      rng(nt, (100 >> (i % 4)) - 2, (100 >> (i % 4)) + 2);
    end
    tog <= 1'b0;
    cfg(16'h0000);
    run(50);
    rng(nt, 49, 51);
    en <= 1'b0;
    cfg(16'h0000);
    run(50);
    chk(16'(nt), 16'h0000);
    tend("clocking");
    en <= 1'b1;
    for (int sel = 0; sel < 8; sel++) begin
      cfg({9'h000, 3'(sel), 4'h7});
      pulse(3'(sel));
      chk(16'(nt), (sel == 4) ? 16'h0002 : 16'h0001);
    end
    cfg(16'h0004);
    pulse(3'h0);
    chk(16'(nr), 16'h0001);
    cfg(16'h0087);
    pulse(3'h0);
    chk(16'(nt), 16'h0001);
    cfg(16'h0005);
    src(3'h0, 1'b1);
    run(40);
    src(3'h0, 1'b0);
    run(4);
    rng(nt, 38, 42);
    nt = 0;
    run(20);
    chk(16'(nt), 16'h0000);
    en <= 1'b0;
    cfg(16'h0006);
    pulse(3'h0);
    chk(16'(ns), 16'h0001);
    tend("slave modes");
    en <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      cfg(16'(k));
      repeat (4) begin
        in2 <= ~in2;
        run(4);
        in1 <= ~in1;
        run(4);
      end
      chk(16'(nt), (k == 3) ? 16'h0008 : 16'h0004);
    end
    cfg(16'h0001);
    in2 <= 1'b1;
    run(4);
    d0 = ld;
    in2 <= 1'b0;
    run(4);
    chk(16'(ld ^ d0), 16'h0001);
    tend("encoder");
    finish_test;
  end
endmodule // tsc_slave_trigger_tb
`default_nettype wire
